//--- rtl/mpct_cfg.svh
// Register offsets, field positions, the ARR reset value and the event count for the timer
`ifndef MPCT_CFG_SVH
`define MPCT_CFG_SVH
`define MPCT_OFF_CTRL 12'h000
`define MPCT_OFF_PSC 12'h004
`define MPCT_OFF_ARR 12'h008
`define MPCT_OFF_CNT 12'h00C
`define MPCT_OFF_STAT 12'h010
`define MPCT_OFF_MASK 12'h014
`define MPCT_OFF_DEAD 12'h018
`define MPCT_OFF_CHCFG 12'h01C
`define MPCT_OFF_CCR0 12'h020
`define MPCT_OFF_SYNC 12'h030
`define MPCT_CTRL_EN 0
`define MPCT_CTRL_DIR 1
`define MPCT_CTRL_CENTER 2
`define MPCT_CTRL_ENC 3
`define MPCT_CTRL_HALL 4
`define MPCT_CTRL_SLAVE 5
`define MPCT_CTRL_DMA 6
`define MPCT_CTRL_W32 7
`define MPCT_ST_UPD 0
`define MPCT_ST_CC0 1
`define MPCT_ST_HALL 5
`define MPCT_ARR_RESET 32'h0000FFFF
`define MPCT_NUM_EV 6
`endif

//--- rtl/mpct_pkg.sv
// Types shared by the multichannel timer
package mpct_pkg;
  typedef enum logic [1:0] {MPCT_CAPTURE, MPCT_COMPARE, MPCT_PWM, MPCT_ONEPULSE} mpct_mode_e;
  typedef struct packed {
    mpct_mode_e mode;
    logic pol;
    logic cap_fall;
  } mpct_chcfg_s;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } mpct_apb_req_s;
endpackage

//--- rtl/mpct_timer.sv
// Prescaled auto-reload timer with four channels, dead time, encoder and hall inputs
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "mpct_cfg.svh"
module mpct_timer (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] cap_in,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic [3:0] hall_in,
  input wire logic sync_in,
  output logic [3:0] ch_out,
  output logic [2:0] ch_out_n,
  output logic sync_out,
  output logic dma_req,
  output logic irq
);
  mpct_pkg::mpct_apb_req_s req;
  logic [7:0] ctrl, next_ctrl;
  logic [15:0] psc, next_psc, pcnt, next_pcnt;
  logic [31:0] arr, next_arr, cnt, next_cnt;
  logic [5:0] stat, next_stat, mask, next_mask;
  logic [7:0] dead, next_dead;
  mpct_pkg::mpct_chcfg_s [3:0] chcfg, next_chcfg;
  logic [31:0] ccr [4];
  logic [31:0] next_ccr [4];
  logic down, next_down;
  logic [3:0] opm_done, next_opm_done;
  logic [3:0] raw, next_raw;
  logic [2:0][7:0] dtc, next_dtc;
  logic [3:0] ch_q, next_ch_q;
  logic [2:0] chn_q, next_chn_q;
  logic [31:0] prdata_q, next_prdata_q;
  logic pready_q, next_pready_q, pslverr_q, next_pslverr_q;
  logic sync_q, next_sync_q, dma_q, next_dma_q, irq_q, next_irq_q;
  logic [3:0] cap_m, cap_s, cap_p;
  logic [1:0] enc_m, enc_s, enc_p;
  logic [3:0] hall_m, hall_s, hall_p;
  logic sync_m, sync_s;
  logic tick, at_top, at_zero, upd, wr, rd, wide;
  logic [31:0] limit;
  logic [3:0] cmp_hit, cap_hit;
  logic enc_step, enc_dn;
  logic [5:0] ev;
  logic [2:0] chg, blank;

  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
  assign wr = req.psel && req.penable && req.pwrite;
  assign rd = req.psel && !req.penable && !req.pwrite;
  assign wide = ctrl[`MPCT_CTRL_W32];
  assign limit = wide ? arr : {16'h0000, arr[15:0]};

  // Width mask used for counter compare and wrap
  function automatic logic [31:0] mpct_trim(input logic [31:0] v, input logic w);
    mpct_trim = w ? v : {16'h0000, v[15:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, first stage read only by the second
  always_ff @(posedge sys_clk) begin
    cap_m <= cap_in;
    cap_s <= cap_m;
    cap_p <= cap_s;
    enc_m <= {enc_a, enc_b};
    enc_s <= enc_m;
    enc_p <= enc_s;
    hall_m <= hall_in;
    hall_s <= hall_m;
    hall_p <= hall_s;
    sync_m <= sync_in;
    sync_s <= sync_m;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event decode
  always_comb begin
    // X4 decode: any single-phase edge is a step; direction from phase order
    enc_step = (enc_s != enc_p);
    enc_dn = enc_s[1] ^ enc_p[0];
    tick = ctrl[`MPCT_CTRL_EN] && (ctrl[`MPCT_CTRL_SLAVE] ? sync_s : 1'b1) &&
      (ctrl[`MPCT_CTRL_ENC] ? enc_step : (pcnt == psc));
    at_top = (mpct_trim(cnt, wide) >= limit);
    at_zero = (mpct_trim(cnt, wide) == 32'h00000000);
    upd = tick && !ctrl[`MPCT_CTRL_ENC] && (down ? at_zero : at_top);
    for (int i = 0; i < 4; i++) begin
      // Capture channels hold a captured value, so they raise no compare event
      cmp_hit[i] = tick && (chcfg[i].mode != mpct_pkg::MPCT_CAPTURE) &&
        (mpct_trim(cnt, wide) == mpct_trim(ccr[i], wide));
      cap_hit[i] = (chcfg[i].mode == mpct_pkg::MPCT_CAPTURE) &&
        (chcfg[i].cap_fall ? (cap_p[i] && !cap_s[i]) : (!cap_p[i] && cap_s[i]));
    end
    ev = {(ctrl[`MPCT_CTRL_HALL] && (hall_s != hall_p)), (cmp_hit | cap_hit), upd};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter, prescaler and direction
  always_comb begin
    next_pcnt = pcnt;
    next_cnt = cnt;
    next_down = down;
    if (!ctrl[`MPCT_CTRL_EN]) begin
      next_pcnt = 16'h0000;
    end else if (pcnt == psc) begin
      next_pcnt = 16'h0000;
    end else begin
      next_pcnt = pcnt + 16'h0001;
    end
    if (!ctrl[`MPCT_CTRL_CENTER]) begin
      next_down = ctrl[`MPCT_CTRL_DIR];
    end
    if (tick) begin
      if (ctrl[`MPCT_CTRL_ENC]) begin
        next_cnt = enc_dn ? (at_zero ? limit : cnt - 32'h00000001) :
          (at_top ? 32'h00000000 : cnt + 32'h00000001);
      end else if (ctrl[`MPCT_CTRL_CENTER]) begin
        // Center mode turns at both ends instead of reloading
        if (down && at_zero) begin
          next_down = 1'b0;
          next_cnt = 32'h00000001;
        end else if (!down && at_top) begin
          next_down = 1'b1;
          next_cnt = limit - 32'h00000001;
        end else begin
          next_cnt = down ? cnt - 32'h00000001 : cnt + 32'h00000001;
        end
      end else if (down) begin
        next_cnt = at_zero ? limit : cnt - 32'h00000001;
      end else begin
        next_cnt = at_top ? 32'h00000000 : cnt + 32'h00000001;
      end
    end
    if (wr && req.paddr == `MPCT_OFF_CNT) begin
      next_cnt = mpct_trim(req.pwdata, wide);
    end
    // Trim to the width of the next cycle, so a narrowing write leaves no high bits
    next_cnt = mpct_trim(next_cnt, next_ctrl[`MPCT_CTRL_W32]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel waveforms
  always_comb begin
    next_raw = raw;
    next_opm_done = opm_done;
    for (int i = 0; i < 4; i++) begin
      unique case (chcfg[i].mode)
        mpct_pkg::MPCT_PWM: begin
          // Compare 0 never active, compare above limit always active
          next_raw[i] = (mpct_trim(next_cnt, wide) < mpct_trim(ccr[i], wide));
        end
        mpct_pkg::MPCT_COMPARE: begin
          if (cmp_hit[i]) begin
            next_raw[i] = !raw[i];
          end
        end
        mpct_pkg::MPCT_ONEPULSE: begin
          if (upd) begin
            next_opm_done[i] = 1'b1;
          end
          next_raw[i] = !opm_done[i] && (mpct_trim(next_cnt, wide) >= mpct_trim(ccr[i], wide));
        end
        mpct_pkg::MPCT_CAPTURE: begin
          next_raw[i] = 1'b0;
        end
      endcase
      if (!ctrl[`MPCT_CTRL_EN]) begin
        next_opm_done[i] = 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Dead time on the three complementary pairs; a change blanks both sides first
  always_comb begin
    next_dtc = dtc;
    next_ch_q = ch_q;
    next_chn_q = chn_q;
    next_ch_q[3] = raw[3] ^ chcfg[3].pol;
    for (int i = 0; i < 3; i++) begin
      // Wanted side differs from the side driven now
      chg[i] = raw[i] ? chn_q[i] : (ch_q[i] ^ chcfg[i].pol);
      blank[i] = (chg[i] && dead != 8'h00) || (dtc[i] != 8'h00);
      if (chg[i] && dead != 8'h00) begin
        next_dtc[i] = dead - 8'h01;
      end else if (dtc[i] != 8'h00) begin
        next_dtc[i] = dtc[i] - 8'h01;
      end
      next_ch_q[i] = (raw[i] && !blank[i]) ^ chcfg[i].pol;
      next_chn_q[i] = !raw[i] && !blank[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file, status and outputs
  always_comb begin
    next_ctrl = ctrl;
    next_psc = psc;
    next_arr = arr;
    next_mask = mask;
    next_dead = dead;
    next_chcfg = chcfg;
    next_ccr = ccr;
    next_stat = stat;
    next_prdata_q = 32'h00000000;
    next_pready_q = req.psel && !req.penable;
    next_pslverr_q = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (cap_hit[i]) begin
        next_ccr[i] = cnt;
      end
    end
    if (wr) begin
      unique case (req.paddr)
        `MPCT_OFF_CTRL: next_ctrl = req.pwdata[7:0];
        `MPCT_OFF_PSC: next_psc = req.pwdata[15:0];
        `MPCT_OFF_ARR: next_arr = req.pwdata;
        `MPCT_OFF_STAT: next_stat = stat & ~req.pwdata[5:0];
        `MPCT_OFF_MASK: next_mask = req.pwdata[5:0];
        `MPCT_OFF_DEAD: next_dead = req.pwdata[7:0];
        `MPCT_OFF_CHCFG: next_chcfg = req.pwdata[15:0];
        `MPCT_OFF_CCR0: next_ccr[0] = req.pwdata;
        12'h024: next_ccr[1] = req.pwdata;
        12'h028: next_ccr[2] = req.pwdata;
        12'h02C: next_ccr[3] = req.pwdata;
        `MPCT_OFF_CNT, `MPCT_OFF_SYNC: ;
        default: next_pslverr_q = 1'b0;
      endcase
    end
    next_stat = next_stat | ev;
    // Reads latch in setup; a write setup never flags an error
    if (rd) begin
      unique case (req.paddr)
        `MPCT_OFF_CTRL: next_prdata_q = {24'h000000, ctrl};
        `MPCT_OFF_PSC: next_prdata_q = {16'h0000, psc};
        `MPCT_OFF_ARR: next_prdata_q = arr;
        `MPCT_OFF_CNT: next_prdata_q = cnt;
        `MPCT_OFF_STAT: next_prdata_q = {26'h0000000, stat};
        `MPCT_OFF_MASK: next_prdata_q = {26'h0000000, mask};
        `MPCT_OFF_DEAD: next_prdata_q = {24'h000000, dead};
        `MPCT_OFF_CHCFG: next_prdata_q = {16'h0000, chcfg};
        `MPCT_OFF_CCR0: next_prdata_q = ccr[0];
        12'h024: next_prdata_q = ccr[1];
        12'h028: next_prdata_q = ccr[2];
        12'h02C: next_prdata_q = ccr[3];
        `MPCT_OFF_SYNC: next_prdata_q = {28'h0000000, hall_s};
        default: next_pslverr_q = 1'b1;
      endcase
    end
    next_sync_q = upd;
    next_dma_q = ctrl[`MPCT_CTRL_DMA] && (upd || (|cap_hit));
    next_irq_q = |(next_stat & next_mask);
  end
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctrl <= 8'h00;
      psc <= 16'h0000;
      pcnt <= 16'h0000;
      arr <= `MPCT_ARR_RESET;
      cnt <= 32'h00000000;
      stat <= 6'h00;
      mask <= 6'h00;
      dead <= 8'h00;
      chcfg <= '0;
      for (int i = 0; i < 4; i++) ccr[i] <= 32'h00000000;
      down <= 1'b0;
      opm_done <= 4'h0;
      raw <= 4'h0;
      dtc <= '0;
      ch_q <= 4'h0;
      chn_q <= 3'h0;
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      sync_q <= 1'b0;
      dma_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      psc <= next_psc;
      pcnt <= next_pcnt;
      arr <= next_arr;
      cnt <= next_cnt;
      stat <= next_stat;
      mask <= next_mask;
      dead <= next_dead;
      chcfg <= next_chcfg;
      for (int i = 0; i < 4; i++) ccr[i] <= next_ccr[i];
      down <= next_down;
      opm_done <= next_opm_done;
      raw <= next_raw;
      dtc <= next_dtc;
      ch_q <= next_ch_q;
      chn_q <= next_chn_q;
      prdata_q <= next_prdata_q;
      pready_q <= next_pready_q;
      pslverr_q <= next_pslverr_q;
      sync_q <= next_sync_q;
      dma_q <= next_dma_q;
      irq_q <= next_irq_q;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign ch_out = ch_q;
  assign ch_out_n = chn_q;
  assign sync_out = sync_q;
  assign dma_req = dma_q;
  assign irq = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_upd_hit;
    upd ##1 1'b1;
  endsequence
  a_update_flag_set: assert property (@(posedge sys_clk) disable iff (reset)
    s_upd_hit |-> stat[`MPCT_ST_UPD]) else $error("update flag missing");
  a_update_reload: assert property (@(posedge sys_clk) disable iff (reset)
    upd && !down && !ctrl[`MPCT_CTRL_CENTER] && !wr |=> cnt == 32'h00000000)
    else $error("up counter did not reload");
  a_down_reload: assert property (@(posedge sys_clk) disable iff (reset)
    upd && down && !ctrl[`MPCT_CTRL_CENTER] && !wr |=> cnt == $past(limit))
    else $error("down counter did not reload");
  a_width_trim: assert property (@(posedge sys_clk) disable iff (reset)
    !wide |-> cnt[31:16] == 16'h0000) else $error("narrow counter overflow");
  a_presc_hold: assert property (@(posedge sys_clk) disable iff (reset)
    ctrl[`MPCT_CTRL_EN] && !ctrl[`MPCT_CTRL_ENC] && !ctrl[`MPCT_CTRL_SLAVE] && pcnt != psc && !wr
    |=> cnt == $past(cnt)) else $error("counter moved between prescaler ticks");
  a_dead_gap: assert property (@(posedge sys_clk) disable iff (reset)
    !(ch_q[0] ^ chcfg[0].pol && chn_q[0])) else $error("pair overlap");
  a_dead_insert: assert property (@(posedge sys_clk) disable iff (reset)
    raw[0] && chn_q[0] && dead != 8'h00 && !wr |=> !chn_q[0] && !(ch_q[0] ^ chcfg[0].pol))
    else $error("dead time skipped");
  a_capture_load: assert property (@(posedge sys_clk) disable iff (reset)
    cap_hit[0] && !wr |=> ccr[0] == $past(cnt)) else $error("capture not loaded");
  a_dma_event: assert property (@(posedge sys_clk) disable iff (reset)
    ctrl[`MPCT_CTRL_DMA] && upd |=> dma_req) else $error("dma request missing");
  a_sync_pulse: assert property (@(posedge sys_clk) disable iff (reset)
    upd |=> sync_out) else $error("sync pulse missing");
  a_irq_level: assert property (@(posedge sys_clk) disable iff (reset)
    |(stat & mask) |-> irq) else $error("interrupt low with pending bit");
  a_hall_flag: assert property (@(posedge sys_clk) disable iff (reset)
    ev[`MPCT_ST_HALL] |=> stat[`MPCT_ST_HALL]) else $error("hall change lost");
  a_center_turn: assert property (@(posedge sys_clk) disable iff (reset)
    tick && ctrl[`MPCT_CTRL_CENTER] && !ctrl[`MPCT_CTRL_ENC] && !down && at_top
    |=> down) else $error("center mode did not turn");
endmodule
`default_nettype wire

//--- tb/mpct_pins_model.sv
// Pin-side model: quadrature encoder, hall sensors and capture pins
`timescale 1ns/100ps
`default_nettype none
module mpct_pins_model (
  input wire logic sys_clk,
  output logic enc_a,
  output logic enc_b,
  output logic [3:0] hall_in,
  output logic [3:0] cap_in
);
  logic [1:0] phase = 2'h0;
  initial begin
    hall_in = 4'h0;
    cap_in = 4'h0;
  end
  // Gray-coded phases, so only one encoder line moves per step
  assign enc_a = phase[1];
  assign enc_b = phase[1] ^ phase[0];
  // Slow steps, four clocks apart, so each edge passes the pin sync
  task automatic enc_steps(input int n, input logic rev);
    repeat (n) begin
      repeat (4) @(posedge sys_clk);
      phase <= rev ? phase - 2'h1 : phase + 2'h1;
    end
  endtask
  task automatic set_hall(input logic [3:0] v);
    @(posedge sys_clk);
    hall_in <= v;
  endtask
  // Pulse held long enough to be seen through a two-stage sync
  task automatic cap_pulse(input int ch);
    @(posedge sys_clk);
    cap_in[ch] <= 1'b1;
    repeat (4) @(posedge sys_clk);
    cap_in[ch] <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- tb/multichannel_pwm_capture_timer_test.sv
// Register-level tests of the multichannel timer
`timescale 1ns/100ps
`default_nettype none
`include "mpct_cfg.svh"
module multichannel_pwm_capture_timer_test;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q, r1, r2;
  logic pready, pslverr, err, enc_a, enc_b, sync_in = 1'b0;
  logic [3:0] cap_in, hall_in, ch_out;
  logic [2:0] ch_out_n;
  logic sync_out, dma_req, irq;
  int n_mismatch = 0, checks = 0, n_sync = 0, n_dma = 0, n_hi = 0;
  int n_both = 0, n_gap = 0, n_rise = 0, cyc = 0, s0, n_hi3 = 0;
  logic last_n = 1'b0;
  mpct_timer dut_u (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cap_in(cap_in), .enc_a(enc_a), .enc_b(enc_b), .hall_in(hall_in),
    .sync_in(sync_in), .ch_out(ch_out), .ch_out_n(ch_out_n), .sync_out(sync_out),
    .dma_req(dma_req), .irq(irq));
  mpct_pins_model pins_u (.sys_clk(sys_clk), .enc_a(enc_a), .enc_b(enc_b),
    .hall_in(hall_in), .cap_in(cap_in));
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  // Event and waveform tallies, plus a hang guard; mid-cycle, so no race with tests
  always @(negedge sys_clk) begin
    cyc++;
    n_sync += (sync_out === 1'b1);
    n_dma += (dma_req === 1'b1);
    n_hi += (ch_out[0] === 1'b1);
    n_hi3 += (ch_out[3] === 1'b1);
    n_both += (ch_out[0] === 1'b1 && ch_out_n[0] === 1'b1);
    n_gap += (ch_out[0] === 1'b0 && ch_out_n[0] === 1'b0);
    n_rise += (ch_out_n[0] === 1'b1 && last_n === 1'b0);
    last_n = ch_out_n[0];
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; waits on pready, no fixed latency assumed
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic near(input int v, input int lo, input int hi);
    check({31'h0, v >= lo && v <= hi}, 32'h1);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    // Reset values and an unmapped read
    rd(`MPCT_OFF_ARR);
    check(q, `MPCT_ARR_RESET);
    rd(`MPCT_OFF_CTRL);
    check(q, 32'h0);
    rd(12'h0FC);
    check({31'h0, err}, 32'h1);
    wr(12'h0FC, 32'h1);
    check({31'h0, err}, 32'h0);
    $display("reset test done");
    // Time base, update flag, masked interrupt, W1C clear
    wr(`MPCT_OFF_PSC, 32'h0);
    wr(`MPCT_OFF_ARR, 32'h4);
    wr(`MPCT_OFF_MASK, 32'h1);
    s0 = n_sync;
    wr(`MPCT_OFF_CTRL, 32'h1);
    repeat (50) @(posedge sys_clk);
    near(n_sync - s0, 9, 12);
    check({31'h0, irq}, 32'h1);
    wr(`MPCT_OFF_CTRL, 32'h0);
    rd(`MPCT_OFF_STAT);
    check(q & 32'h1, 32'h1);
    wr(`MPCT_OFF_STAT, 32'h1);
    repeat (2) @(posedge sys_clk);
    check({31'h0, irq}, 32'h0);
    wr(`MPCT_OFF_MASK, 32'h0);
    wr(`MPCT_OFF_CTRL, 32'h1);
    repeat (20) @(posedge sys_clk);
    check({31'h0, irq}, 32'h0);
    $display("time base test done");
    // DMA request per update, none when disabled
    s0 = n_dma;
    wr(`MPCT_OFF_CTRL, 32'h41);
    repeat (50) @(posedge sys_clk);
    near(n_dma - s0, 9, 12);
    wr(`MPCT_OFF_CTRL, 32'h1);
    repeat (2) @(posedge sys_clk);
    s0 = n_dma;
    repeat (50) @(posedge sys_clk);
    check(n_dma - s0, 32'h0);
    // Counting direction
    wr(`MPCT_OFF_ARR, 32'hFFFF);
    rd(`MPCT_OFF_CNT);
    r1 = q;
    rd(`MPCT_OFF_CNT);
    near(q - r1, 1, 15);
    wr(`MPCT_OFF_CTRL, 32'h3);
    rd(`MPCT_OFF_CNT);
    r1 = q;
    rd(`MPCT_OFF_CNT);
    near(r1 - q, 1, 15);
    // Counting gated by the peer timer's sync level
    wr(`MPCT_OFF_CTRL, 32'h21);
    rd(`MPCT_OFF_CNT);
    r1 = q;
    rd(`MPCT_OFF_CNT);
    check(q, r1);
    sync_in <= 1'b1;
    rd(`MPCT_OFF_CNT);
    r1 = q;
    rd(`MPCT_OFF_CNT);
    near(q - r1, 1, 15);
    sync_in <= 1'b0;
    $display("dma and direction tests done");
    // PWM duty ends, center mode, dead time
    wr(`MPCT_OFF_ARR, 32'h9);
    wr(`MPCT_OFF_CHCFG, 32'h8);
    wr(`MPCT_OFF_CCR0, 32'h0);
    wr(`MPCT_OFF_CTRL, 32'h1);
    repeat (5) @(posedge sys_clk);
    s0 = n_hi;
    repeat (40) @(posedge sys_clk);
    check(n_hi - s0, 32'h0);
    wr(`MPCT_OFF_CCR0, 32'hA);
    repeat (5) @(posedge sys_clk);
    s0 = n_hi;
    repeat (40) @(posedge sys_clk);
    check(n_hi - s0, 32'd40);
    wr(`MPCT_OFF_CCR0, 32'h5);
    wr(`MPCT_OFF_CTRL, 32'h5);
    s0 = n_hi;
    repeat (40) @(posedge sys_clk);
    near(n_hi - s0, 1, 39);
    wr(`MPCT_OFF_CTRL, 32'h1);
    wr(`MPCT_OFF_DEAD, 32'h2);
    s0 = n_rise;
    r1 = n_both;
    r2 = n_gap;
    repeat (60) @(posedge sys_clk);
    check(n_both - r1, 32'h0);
    near(n_rise - s0, 1, 60);
    near(n_gap - r2, 4, 60);
    // Compare toggle, then a single pulse, on channel 3
    wr(12'h02C, 32'h3);
    wr(`MPCT_OFF_CHCFG, 32'h4008);
    s0 = n_hi3;
    repeat (40) @(posedge sys_clk);
    near(n_hi3 - s0, 10, 30);
    wr(`MPCT_OFF_CTRL, 32'h0);
    wr(`MPCT_OFF_CHCFG, 32'hC008);
    wr(`MPCT_OFF_CNT, 32'h0);
    wr(`MPCT_OFF_CTRL, 32'h1);
    s0 = n_hi3;
    repeat (60) @(posedge sys_clk);
    near(n_hi3 - s0, 6, 8);
    $display("pwm test done");
    // Capture edges set their channel flags and load the count
    wr(`MPCT_OFF_CHCFG, 32'h0);
    wr(12'h024, 32'hFF);
    wr(`MPCT_OFF_STAT, 32'h3F);
    pins_u.cap_pulse(0);
    pins_u.cap_pulse(1);
    repeat (6) @(posedge sys_clk);
    rd(`MPCT_OFF_STAT);
    check(q & 32'h6, 32'h6);
    rd(12'h024);
    near(q, 0, 9);
    // Wide counter keeps high bits; narrowing trims them
    wr(`MPCT_OFF_CTRL, 32'h80);
    wr(`MPCT_OFF_ARR, 32'h00020000);
    wr(`MPCT_OFF_CNT, 32'h00010000);
    rd(`MPCT_OFF_CNT);
    check(q, 32'h00010000);
    wr(`MPCT_OFF_CTRL, 32'h0);
    rd(`MPCT_OFF_CNT);
    check(q, 32'h0);
    // Encoder forwards then backwards
    wr(`MPCT_OFF_ARR, 32'hFFFF);
    wr(`MPCT_OFF_CTRL, 32'h9);
    wr(`MPCT_OFF_CNT, 32'd100);
    pins_u.enc_steps(8, 1'b0);
    repeat (6) @(posedge sys_clk);
    rd(`MPCT_OFF_CNT);
    r1 = q;
    near(r1, 101, 132);
    pins_u.enc_steps(8, 1'b1);
    repeat (6) @(posedge sys_clk);
    rd(`MPCT_OFF_CNT);
    near(q, 99, r1 - 1);
    // Hall levels and change flag
    wr(`MPCT_OFF_CTRL, 32'h11);
    wr(`MPCT_OFF_STAT, 32'h3F);
    pins_u.set_hall(4'hA);
    repeat (6) @(posedge sys_clk);
    rd(`MPCT_OFF_SYNC);
    check(q & 32'hF, 32'hA);
    rd(`MPCT_OFF_STAT);
    check(q & 32'h20, 32'h20);
    $display("capture encoder hall tests done");
    test_done();
  end
endmodule
`default_nettype wire
